/* hdl/lbf_pkg.sv */
// Purpose: shared constants and types for the backlight fade control block
// Assumes: 100 MHz core clock, six-bit register data from the pulse-link decoder
// Notes: offsets are register addresses delivered by the link decoder
package lbf_pkg;
    localparam int CLK_MHZ = 100;
    // register addresses
    localparam logic [4:0] ADDR_ENABLE = 5'h00;
    localparam logic [4:0] ADDR_MAIN_CUR = 5'h01;
    localparam logic [4:0] ADDR_BANK2_CUR = 5'h02;
    localparam logic [4:0] ADDR_BANK3_CUR = 5'h03;
    localparam logic [4:0] ADDR_FADE = 5'h04;
    localparam logic [4:0] ADDR_GROUP = 5'h05;
    // reset values
    localparam logic [5:0] ENABLE_RST = 6'h00;
    localparam logic [5:0] CUR_RST = 6'h00;
    localparam logic [5:0] FADE_RST = 6'h00;
    localparam logic [5:0] GROUP_RST = 6'h00;
    localparam logic [1:0] FADE_OFF = 2'h0;
    // code map: 4..13 = 0.5 mA steps, 14..29 = 1 mA, 30..31 = 2 mA
    localparam logic [5:0] CODE_HALF_MA = 6'h04; // lowest step, 0.5 mA
    localparam logic [5:0] CODE_5MA = 6'h0D;
    localparam logic [5:0] CODE_21MA = 6'h1D;
    localparam logic [5:0] CODE_MAX = 6'h1F;
    localparam logic [5:0] LEVEL_5MA = 6'h0A; // 5 mA in half-mA units
    localparam logic [5:0] LEVEL_21MA = 6'h2A; // 21 mA in half-mA units
    localparam logic [5:0] LEVEL_MAX = 6'h32; // 25 mA in half-mA units
    localparam logic [5:0] LOWBIAS_HALF_MA = 6'h08; // 4.0 mA
    // charge pump clock
    localparam int PUMP_KHZ = 250;
    localparam int PUMP_HALF_CYC = CLK_MHZ * 1000 / PUMP_KHZ / 2;
    // shutdown low time, least time in ms
    localparam int SHUTDOWN_LOW_MS = 10;
    localparam int SHUTDOWN_CYC = SHUTDOWN_LOW_MS * CLK_MHZ * 1000;
    localparam int NUM_LED = 5;

    typedef enum logic [1:0] {LBF_PUMP_1X, LBF_PUMP_1P5X, LBF_PUMP_2X} lbf_pump_e;
    typedef enum logic {LBF_F_IDLE, LBF_F_STEP} lbf_fade_e;

    typedef struct packed {
        logic valid;
        logic [4:0] addr;
        logic [5:0] data;
    } lbf_wr_s;

    typedef struct packed {
        logic need_up;
        logic headroom_ok;
    } lbf_demand_s;
endpackage : lbf_pkg

/* hdl/lbf_fade_ctrl.sv */
// Purpose: register file, banks, code map, fade engine, pump and shutdown control
// Assumes: decoded register writes arrive as one-cycle pulses from the link decoder
// Notes: analog levels leave as half-milliamp codes per sink
// Summary of operation
// RULE1 - pump clock 250 kHz in boosted modes
// RULE2 - pick lowest sufficient pump mode, hysteresis
// RULE3 - codes map to 0-25 mA nonuniform steps
// RULE4 - sink off by enable or zero code
// RULE5 - regulation feedback uses lowest sink
// RULE6 - all sinks off after power-up
// RULE7 - host clears enables of unused outputs
// RULE8 - reduced bias at or below 4 mA
// RULE9 - five drivers grouped into three banks
// RULE10 - fade steps through every intermediate code
// RULE11 - fade acts only on main bank
// RULE12 - rate change keeps running fade
// RULE13 - new main code retargets fade
// RULE14 - fade disable jumps to target
// RULE15 - rate code zero disables fading
// RULE16 - code zero 0 mA, code four 0.5 mA
// RULE17 - host fade-in five-write sequence
// RULE18 - host fade-out: rate then zero
// RULE19 - host level fade: rate then code
// RULE20 - long low on pin shuts down
// RULE21 - shutdown restores register defaults
// RULE22 - shutdown low at least 10 ms
// RULE23 - six data bits per register
// RULE24 - all disabled means sleep, clock stops
// RULE25 - fade step interval per rate parameter
// RULE26 - present and target level registers
`timescale 1ns/1ps
`default_nettype none
module lbf_fade_ctrl
    import lbf_pkg::*;
#(
    parameter int STEP_CYC_1 = 1000,
    parameter int STEP_CYC_2 = 2000,
    parameter int STEP_CYC_3 = 4000,
    parameter int SHUTDOWN_CYCLES = SHUTDOWN_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // link pin level and decoded writes
    input wire logic pulse_wire_pin,
    input wire lbf_wr_s wr_in,
    // analog feedback
    input wire logic [NUM_LED-1:0] sink_headroom_low,
    input wire lbf_demand_s demand,
    // sink drive
    output logic [NUM_LED-1:0] sink_on,
    output logic [NUM_LED*6-1:0] sink_level,
    output logic [NUM_LED-1:0] fb_select,
    // pump and bias
    output logic pump_clk,
    output lbf_pump_e pump_mode,
    output logic low_bias,
    output logic sleep,
    output logic shutdown
);
    localparam logic [31:0] SD_CYC = 32'(SHUTDOWN_CYCLES);

    // code to half-milliamp level
    function automatic logic [5:0] code_to_half_ma(input logic [5:0] c);
        logic [5:0] r;
        r = 6'h00;
        // RULE3 nonuniform step map
        // RULE16 zero and four codes
        if (c == CUR_RST)
            r = 6'h00;
        else if (c <= CODE_HALF_MA)
            r = 6'h01; // codes below four also give the lowest step
        else if (c <= CODE_5MA)
            r = c - (CODE_HALF_MA - 6'h01);
        else if (c <= CODE_21MA)
            r = 6'(LEVEL_5MA + 2 * (c - CODE_5MA));
        else if (c <= CODE_MAX)
            r = 6'(LEVEL_21MA + 4 * (c - CODE_21MA));
        else
            r = LEVEL_MAX;
        return r;
    endfunction : code_to_half_ma

    logic [5:0] en_r, en_nxt, grp_r, grp_nxt, fade_r, fade_nxt;
    logic [5:0] b2_r, b2_nxt, b3_r, b3_nxt;
    logic [5:0] tgt_r, tgt_nxt, cur_r, cur_nxt;
    logic [31:0] stc_r, stc_nxt, sdc_r, sdc_nxt;
    logic [31:0] step_len;
    lbf_fade_e fst_r, fst_nxt;
    logic sd_r, sd_nxt;
    logic clr;

    // shutdown detector and register defaults
    always_comb begin
        sdc_nxt = sdc_r;
        sd_nxt = sd_r;
        // RULE20 long low detect
        // RULE22 at least 10 ms
        if (pulse_wire_pin) begin
            sdc_nxt = 32'h0;
            sd_nxt = 1'b0;
        end else if (sdc_r < SD_CYC - 32'h1) begin
            sdc_nxt = sdc_r + 32'h1;
        end else begin
            sd_nxt = 1'b1;
        end
    end
    assign clr = sd_nxt && !sd_r;

    // fade step length from the rate code
    // RULE25 step interval per rate
    always_comb begin
        case (fade_r[1:0])
            2'h1: step_len = 32'(STEP_CYC_1);
            2'h2: step_len = 32'(STEP_CYC_2);
            default: step_len = 32'(STEP_CYC_3);
        endcase
    end

    // register writes and fade engine
    always_comb begin
        en_nxt = en_r;
        grp_nxt = grp_r;
        fade_nxt = fade_r;
        b2_nxt = b2_r;
        b3_nxt = b3_r;
        tgt_nxt = tgt_r;
        cur_nxt = cur_r;
        stc_nxt = stc_r;
        fst_nxt = fst_r;
        // RULE23 six-bit data
        if (wr_in.valid && !sd_r) begin
            unique case (wr_in.addr)
                ADDR_ENABLE: en_nxt = wr_in.data;
                ADDR_MAIN_CUR: tgt_nxt = wr_in.data;
                // RULE11 other banks immediate
                ADDR_BANK2_CUR: b2_nxt = wr_in.data;
                ADDR_BANK3_CUR: b3_nxt = wr_in.data;
                ADDR_FADE: fade_nxt = wr_in.data;
                ADDR_GROUP: grp_nxt = wr_in.data;
                default: ;
            endcase
        end
        unique case (fst_r)
            LBF_F_IDLE: begin
                // RULE15 rate zero is no fade
                // RULE14 immediate when fade off
                if (fade_nxt[1:0] == FADE_OFF) begin
                    cur_nxt = tgt_nxt;
                end else if (tgt_nxt != cur_r) begin
                    // RULE10 start stepping
                    fst_nxt = LBF_F_STEP;
                    stc_nxt = 32'h0;
                end
            end
            LBF_F_STEP: begin
                // RULE14 cancel jumps to target
                if (fade_nxt[1:0] == FADE_OFF) begin
                    cur_nxt = tgt_nxt;
                    fst_nxt = LBF_F_IDLE;
                // RULE12 live rate in step_len
                end else if (stc_r + 32'h1 >= step_len) begin
                    stc_nxt = 32'h0;
                    // RULE13 retarget from present
                    // RULE26 one code per step
                    if (tgt_nxt > cur_r)
                        cur_nxt = cur_r + 6'h01;
                    else if (tgt_nxt < cur_r)
                        cur_nxt = cur_r - 6'h01;
                    if (cur_nxt == tgt_nxt)
                        fst_nxt = LBF_F_IDLE;
                end else begin
                    stc_nxt = stc_r + 32'h1;
                end
            end
        endcase
        // RULE21 defaults on shutdown
        if (clr) begin
            en_nxt = ENABLE_RST;
            grp_nxt = GROUP_RST;
            fade_nxt = FADE_RST;
            b2_nxt = CUR_RST;
            b3_nxt = CUR_RST;
            tgt_nxt = CUR_RST;
            cur_nxt = CUR_RST;
            stc_nxt = 32'h0;
            fst_nxt = LBF_F_IDLE;
        end
    end

    // RULE6 sinks off at reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            en_r <= ENABLE_RST;
            grp_r <= GROUP_RST;
            fade_r <= FADE_RST;
            b2_r <= CUR_RST;
            b3_r <= CUR_RST;
            tgt_r <= CUR_RST;
            cur_r <= CUR_RST;
            stc_r <= 32'h0;
            fst_r <= LBF_F_IDLE;
            sdc_r <= 32'h0;
            sd_r <= 1'b0;
        end else begin
            en_r <= en_nxt;
            grp_r <= grp_nxt;
            fade_r <= fade_nxt;
            b2_r <= b2_nxt;
            b3_r <= b3_nxt;
            tgt_r <= tgt_nxt;
            cur_r <= cur_nxt;
            stc_r <= stc_nxt;
            fst_r <= fst_nxt;
            sdc_r <= sdc_nxt;
            sd_r <= sd_nxt;
        end
    end

    // per-sink bank selection and level
    logic [NUM_LED-1:0] on_nxt, fb_nxt;
    logic [NUM_LED*6-1:0] lvl_nxt;
    logic [5:0] min_lvl;
    logic [NUM_LED-1:0] on_r, fb_r;
    logic [NUM_LED*6-1:0] lvl_r;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LED; gi++) begin : g_sink
            logic [5:0] code;
            // RULE9 bank choice per sink
            if (gi < 2) begin : g_main
                // sinks 0..1 always follow the main bank
                assign code = cur_r;
            end else begin : g_bank
                // sinks 2..4 take a two-bit group field pair
                always_comb begin
                    if (grp_r[gi-2] && grp_r[gi+1])
                        code = b3_r;
                    else if (grp_r[gi-2])
                        code = b2_r;
                    else
                        code = cur_r;
                end
            end
            // RULE4 enable or zero code
            assign on_nxt[gi] = en_r[gi] && (code != CUR_RST) && !sd_r;
            assign lvl_nxt[gi*6 +: 6] = on_nxt[gi] ? code_to_half_ma(code) : 6'h00;
        end
    endgenerate

    // RULE5 lowest-numbered active sink with low headroom feeds regulation, none if no active sink has low headroom
    always_comb begin
        min_lvl = 6'h3F;
        fb_nxt = '0;
        for (int i = 0; i < NUM_LED; i++) begin
            if (on_nxt[i] && sink_headroom_low[i] && fb_nxt == '0)
                fb_nxt[i] = 1'b1;
        end
        for (int i = 0; i < NUM_LED; i++) begin
            if (on_nxt[i] && lvl_nxt[i*6 +: 6] < min_lvl)
                min_lvl = lvl_nxt[i*6 +: 6];
        end
    end

    // pump mode, pump clock, bias and sleep
    lbf_pump_e pm_r, pm_nxt;
    logic [15:0] pdiv_r, pdiv_nxt;
    logic pclk_r, pclk_nxt, lb_r, lb_nxt, slp_r, slp_nxt;
    always_comb begin
        pm_nxt = pm_r;
        // RULE2 step up on demand, down with headroom
        if (demand.need_up && pm_r != LBF_PUMP_2X)
            pm_nxt = (pm_r == LBF_PUMP_1X) ? LBF_PUMP_1P5X : LBF_PUMP_2X;
        else if (demand.headroom_ok && !demand.need_up && pm_r != LBF_PUMP_1X)
            pm_nxt = (pm_r == LBF_PUMP_2X) ? LBF_PUMP_1P5X : LBF_PUMP_1X;
        // RULE24 sleep when all disabled
        slp_nxt = (on_nxt == '0);
        if (slp_nxt)
            pm_nxt = LBF_PUMP_1X;
        pdiv_nxt = pdiv_r;
        pclk_nxt = pclk_r;
        // RULE1 fixed rate, stopped in 1x
        if (pm_nxt == LBF_PUMP_1X) begin
            pdiv_nxt = 16'h0;
            pclk_nxt = 1'b0;
        end else if (pdiv_r >= 16'(PUMP_HALF_CYC - 1)) begin
            pdiv_nxt = 16'h0;
            pclk_nxt = !pclk_r;
        end else begin
            pdiv_nxt = pdiv_r + 16'h1;
        end
        // RULE8 low bias at or below 4 mA
        lb_nxt = (min_lvl == 6'h3F) || (min_lvl <= LOWBIAS_HALF_MA);
    end

    // output registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            on_r <= '0;
            lvl_r <= '0;
            fb_r <= '0;
            pm_r <= LBF_PUMP_1X;
            pdiv_r <= 16'h0;
            pclk_r <= 1'b0;
            lb_r <= 1'b1;
            slp_r <= 1'b1;
        end else begin
            on_r <= on_nxt;
            lvl_r <= lvl_nxt;
            fb_r <= fb_nxt;
            pm_r <= pm_nxt;
            pdiv_r <= pdiv_nxt;
            pclk_r <= pclk_nxt;
            lb_r <= lb_nxt;
            slp_r <= slp_nxt;
        end
    end

    assign sink_on = on_r;
    assign sink_level = lvl_r;
    assign fb_select = fb_r;
    assign pump_clk = pclk_r;
    assign pump_mode = pm_r;
    assign low_bias = lb_r;
    assign sleep = slp_r;
    assign shutdown = sd_r;
endmodule : lbf_fade_ctrl
`default_nettype wire

/* tb/lbf_fade_ctrl_checker.sv */
// Purpose: port-level assertions for the backlight fade control block
// Assumes: sync active-low reset, one clock domain
// Notes: bound onto every lbf_fade_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module lbf_fade_ctrl_checker
    import lbf_pkg::*;
#(
    parameter int SHUTDOWN_CYCLES = 50
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // watched signals
    input wire logic pulse_wire_pin,
    input wire logic [NUM_LED-1:0] sink_on,
    input wire logic [NUM_LED*6-1:0] sink_level,
    input wire logic [NUM_LED-1:0] fb_select,
    input wire logic pump_clk,
    input wire lbf_pump_e pump_mode,
    input wire logic sleep,
    input wire logic shutdown
);
    int low_cnt;
    int low_nxt;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // count cycles of low pin level
    always_comb begin
        low_nxt = pulse_wire_pin ? 0 : low_cnt + 1;
    end
    always_ff @(posedge core_clk) begin
        low_cnt <= rst_n ? low_nxt : 0;
    end
    property p_rst;
        $rose(rst_n) |-> sink_on == '0 && sleep && pump_mode == LBF_PUMP_1X;
    endproperty
    a_rst: assert property (p_rst) else $error("sinks not off after reset");
    property p_fb;
        $onehot0(fb_select);
    endproperty
    a_fb: assert property (p_fb) else $error("feedback select not one-hot");
    property p_pump_1x;
        (pump_mode == LBF_PUMP_1X)[*2] |-> !pump_clk;
    endproperty
    a_pump_1x: assert property (p_pump_1x) else $error("pump clock runs in 1x");
    property p_sleep_1x;
        sleep[*2] |-> pump_mode == LBF_PUMP_1X;
    endproperty
    a_sleep_1x: assert property (p_sleep_1x) else $error("pump boosted in sleep");
    property p_sleep_on;
        (sink_on != '0)[*2] |-> !sleep;
    endproperty
    a_sleep_on: assert property (p_sleep_on) else $error("sleep with sink on");
    property p_shut_regs;
        shutdown[*3] |-> sink_on == '0 && sink_level == '0;
    endproperty
    a_shut_regs: assert property (p_shut_regs) else $error("sink active in shutdown");
    property p_shut_min;
        $rose(shutdown) |-> low_cnt >= SHUTDOWN_CYCLES - 1;
    endproperty
    a_shut_min: assert property (p_shut_min) else $error("shutdown on short low");
    property p_shut_max;
        low_cnt > SHUTDOWN_CYCLES + 2 |-> shutdown;
    endproperty
    a_shut_max: assert property (p_shut_max) else $error("no shutdown on long low");
endmodule : lbf_fade_ctrl_checker
bind lbf_fade_ctrl lbf_fade_ctrl_checker #(.SHUTDOWN_CYCLES(SHUTDOWN_CYCLES)) lbf_fade_ctrl_checker_i (
    .core_clk(core_clk), .rst_n(rst_n), .pulse_wire_pin(pulse_wire_pin),
    .sink_on(sink_on), .sink_level(sink_level), .fb_select(fb_select),
    .pump_clk(pump_clk), .pump_mode(pump_mode), .sleep(sleep), .shutdown(shutdown));
`default_nettype wire

/* tb/lbf_host_model.sv */
// Purpose: host side of the link, issuing decoded writes and pin levels
// Assumes: driven at the falling clock edge
// Notes: released write fields show inverted data
`timescale 1ns/1ps
`default_nettype none
module lbf_host_model
    import lbf_pkg::*;
(
    // clock
    input wire logic core_clk,
    // link side
    output var lbf_wr_s wr_in,
    output var logic pulse_wire_pin
);
    // idle: no write, pin high
    initial begin
        wr_in = '0;
        pulse_wire_pin = 1'b1;
    end
    task automatic put(input logic [4:0] a, input logic [5:0] d);
        @(negedge core_clk);
        wr_in <= '{1'b1, a, d};
        @(negedge core_clk);
        wr_in <= '{1'b0, ~a, ~d};
    endtask : put
    task automatic pin(input logic v);
        @(negedge core_clk);
        pulse_wire_pin <= v;
    endtask : pin
endmodule : lbf_host_model
`default_nettype wire

/* tb/tb.sv */
// Purpose: self-checking bench for the backlight fade control block
// Assumes: short step and shutdown counts for simulation
// Notes: stimulus changes at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lbf_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n;
    logic [4:0] hr;
    lbf_demand_s dem;
    wire logic pulse_wire_pin;
    wire lbf_wr_s wr_in;
    logic [4:0] sink_on;
    logic [4:0] fb_select;
    logic [29:0] sink_level;
    logic pump_clk;
    logic low_bias;
    logic sleep;
    logic shutdown;
    lbf_pump_e pump_mode;
    int fail_count = 0;
    int num_checks = 0;
    int n;
    logic [5:0] cds [10] = '{6'h00, 6'h04, 6'h05, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h1D, 6'h1E, 6'h1F};
    logic [5:0] lvs [10] = '{6'h00, 6'h01, 6'h02, 6'h08, 6'h09, 6'h0A, 6'h0C, 6'h2A, 6'h2E, 6'h32};
    // clock
    always #5 core_clk = ~core_clk;
    lbf_host_model lbf_host_model_i (.core_clk(core_clk), .wr_in(wr_in),
        .pulse_wire_pin(pulse_wire_pin));
    lbf_fade_ctrl #(.STEP_CYC_1(2), .STEP_CYC_2(3), .STEP_CYC_3(4), .SHUTDOWN_CYCLES(50))
    lbf_fade_ctrl_i (.core_clk(core_clk), .rst_n(rst_n), .pulse_wire_pin(pulse_wire_pin),
        .wr_in(wr_in), .sink_headroom_low(hr), .demand(dem), .sink_on(sink_on),
        .sink_level(sink_level), .fb_select(fb_select), .pump_clk(pump_clk),
        .pump_mode(pump_mode), .low_bias(low_bias), .sleep(sleep), .shutdown(shutdown));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk);
    endtask : cyc
    // wait for main level to equal v, or to change when chg is set
    task automatic wait_lvl(input logic chg, input logic [5:0] v, output int k);
        logic [5:0] o;
        o = sink_level[5:0];
        k = 0;
        while (chg ? sink_level[5:0] === o : sink_level[5:0] !== v) begin
            k++;
            @(negedge core_clk);
            if (k > 3000) begin
                chk(0, 1);
                report_and_stop;
            end
        end
    endtask : wait_lvl
    task automatic t_codes;
        lbf_host_model_i.put(ADDR_ENABLE, 6'h03);
        for (int i = 0; i < 10; i++) begin
            lbf_host_model_i.put(ADDR_MAIN_CUR, cds[i]);
            cyc(3);
            chk(sink_level[5:0], lvs[i]);
            chk(sink_on[0], lvs[i] != 0);
            chk(low_bias, lvs[i] <= 8);
        end
        lbf_host_model_i.put(ADDR_ENABLE, 6'h00);
        cyc(3);
        chk(sink_on, 5'h00);
    endtask : t_codes
    task automatic t_fade;
        lbf_host_model_i.put(ADDR_GROUP, 6'h01);
        lbf_host_model_i.put(ADDR_FADE, 6'h00);
        lbf_host_model_i.put(ADDR_MAIN_CUR, 6'h04);
        lbf_host_model_i.put(ADDR_FADE, 6'h01);
        lbf_host_model_i.put(ADDR_ENABLE, 6'h07);
        cyc(3);
        chk(sink_level[5:0], 6'h01);
        lbf_host_model_i.put(ADDR_MAIN_CUR, 6'h08);
        wait_lvl(1'b0, 6'h02, n);
        for (int v = 6; v <= 8; v++) begin
            wait_lvl(1'b0, 6'(v - 3), n);
            chk(n, 2);
        end
        lbf_host_model_i.put(ADDR_MAIN_CUR, 6'h1C);
        lbf_host_model_i.put(ADDR_BANK2_CUR, 6'h10);
        cyc(2);
        chk(sink_level[17:12], 6'h10);
        chk(sink_level[5:0] < 6'h28, 1'b1);
        lbf_host_model_i.put(ADDR_FADE, 6'h03);
        wait_lvl(1'b1, 6'h00, n);
        wait_lvl(1'b1, 6'h00, n);
        chk(n, 4);
        chk(sink_level[5:0] > 6'h05, 1'b1);
        lbf_host_model_i.put(ADDR_MAIN_CUR, 6'h09);
        wait_lvl(1'b0, 6'h06, n);
        cyc(12);
        chk(sink_level[5:0], 6'h06);
        lbf_host_model_i.put(ADDR_FADE, 6'h01);
        lbf_host_model_i.put(ADDR_MAIN_CUR, 6'h00);
        wait_lvl(1'b0, 6'h00, n);
        chk(n > 9, 1'b1);
        lbf_host_model_i.put(ADDR_MAIN_CUR, 6'h1C);
        cyc(6);
        lbf_host_model_i.put(ADDR_FADE, 6'h00);
        cyc(3);
        chk(sink_level[5:0], 6'h28);
    endtask : t_fade
    task automatic t_pump;
        dem = '{1'b1, 1'b0};
        cyc(3);
        n = 0;
        while (pump_clk !== 1'b1 && n < 3000) begin
            n++;
            cyc(1);
        end
        chk(pump_mode, LBF_PUMP_2X);
        n = 0;
        while (pump_clk === 1'b1 && n < 400) begin
            n++;
            cyc(1);
        end
        chk(n, 200);
        hr = 5'b00110;
        cyc(3);
        chk(fb_select, 5'b00010);
        dem = '{1'b0, 1'b1};
        lbf_host_model_i.put(ADDR_ENABLE, 6'h00);
        cyc(3);
        chk(sleep, 1'b1);
        chk(pump_clk, 1'b0);
    endtask : t_pump
    task automatic t_shut;
        lbf_host_model_i.put(ADDR_ENABLE, 6'h03);
        lbf_host_model_i.pin(1'b0);
        cyc(40);
        chk(shutdown, 1'b0);
        lbf_host_model_i.pin(1'b1);
        lbf_host_model_i.pin(1'b0);
        cyc(55);
        chk(shutdown, 1'b1);
        chk(sink_on, 5'h00);
        lbf_host_model_i.put(ADDR_MAIN_CUR, 6'h10);
        lbf_host_model_i.pin(1'b1);
        cyc(4);
        lbf_host_model_i.put(ADDR_ENABLE, 6'h03);
        cyc(3);
        chk(sink_on, 5'h00);
    endtask : t_shut
    // main sequence
    initial begin
        rst_n = 1'b0;
        hr = '0;
        dem = '0;
        cyc(8);
        rst_n = 1'b1;
        cyc(1);
        chk(sink_on, 5'h00);
        chk(sleep, 1'b1);
        t_codes;
        t_fade;
        t_pump;
        t_shut;
        report_and_stop;
    end
endmodule : tb
`default_nettype wire
